// ==== include/dadc_regs.vh ====
// constants for the dual-channel converter frame and power control block
// assumes a 100 MHz mclk that oversamples the host serial pins
//
// Function
// - config write with bit 11 clear, bit 10 set selects single-output readout
// - single-output readout keeps the channel-B output undriven
// - chip-select fall drives zero on channel A during the conversion interval
// - single-output mode launches channel-A MSB at falling edge sixteen
// - then remaining A bits, sixteen B bits MSB first, then zeros
// - single-output frame needs 48 falling edges to count as valid
// - chip-select rise ends the frame and releases every data output
// - normal operation keeps analog circuits powered, internal reference only when bit 6 set, ready every frame
// - light standby keeps internal reference when bit 6 set; DAC values kept
// - valid write setting bit 5 enters light standby at frame end
// - light standby drives ones while selected, releases outputs otherwise
// - valid 48-edge config write clearing bit 5 leaves standby at frame end
// - host waits standby wake delay; exit-frame bits 11 to 6 apply
// - deep power-down switches everything off but keeps DAC values
// - serial input high for 48 edges enters deep power-down at frame end
// - deep power-down keeps both outputs released whatever chip select does
// - serial input low for 48 edges starts power-up at frame end
// - first frame after wake is a valid write; its output is ignored
// - early chip-select rise aborts the frame; next frame samples anew
// - a write in an aborted frame is dropped; configuration stays as before
// - first four serial bits choose operation and register, twelve follow
// - default dual-output readout, where 32 falling edges validate a frame
`ifndef DADC_REGS_VH
`define DADC_REGS_VH

// register offsets
`define DADC_OFS_CONFIG        2'h0
`define DADC_OFS_REFERENCE_DAC_REGISTER        2'h2

// config field positions and reset values
`define DADC_CFG_MODE_HI       11
`define DADC_CFG_MODE_LO       10
`define DADC_CFG_REF_SEL       6
`define DADC_CFG_STANDBY       5
`define DADC_CFG_RESET         12'h000
`define DADC_DAC_RESET         9'h000

// command nibble codes
`define DADC_CMD_RD_DAC_A      4'h1
`define DADC_CMD_RD_DAC_B      4'h2
`define DADC_CMD_RD_CONFIG     4'h3
`define DADC_CMD_WR_CONFIG     4'h8
`define DADC_CMD_WR_DAC_A      4'h9
`define DADC_CMD_WR_DAC_B      4'hA
`define DADC_CMD_NONE          4'h0

// edge counts within a frame
`define DADC_EDGES_DUAL        6'h20
`define DADC_EDGES_SINGLE      6'h30
`define DADC_EDGES_CMD         6'h10
`define DADC_EDGE_MSB          6'h10
`define DADC_EDGE_LAST_DUAL    6'h1F
`define DADC_EDGE_LAST_SINGLE  6'h2F
`define DADC_EDGE_RB_FIRST     6'h01
`define DADC_EDGE_RB_LAST      6'h10
`define DADC_EDGE_MAX          6'h3F

`endif

// ==== verilog/dadc_frame_ctrl.v ====
// frame, readout and power-mode control of a two-channel sampling converter
// assumes host pins cs_n, sclk and serial_input arrive asynchronously and
// are oversampled by mclk; sclk must stay well below mclk / 4
`timescale 1ns/1ps
`default_nettype none
`include "dadc_regs.vh"

module dadc_frame_ctrl (
	// clock and reset
	input  wire        mclk,
	input  wire        rst,
	// host serial pins
	input  wire        cs_n,
	input  wire        sclk,
	input  wire        serial_input,
	// conversion results of the current sample
	input  wire [15:0] result_a,
	input  wire [15:0] result_b,
	// channel A data output pin
	output reg         data_out_channel_a,
	output reg         data_out_channel_a_oe,
	// channel B data output pin
	output reg         data_out_channel_b,
	output reg         data_out_channel_b_oe,
	// power and analog control
	output reg         sample_start,
	output reg         analog_power_on,
	output reg         reference_power_on,
	output reg         standby_active,
	output reg         deep_power_down,
	// register contents
	output reg  [11:0] config_register,
	output reg  [8:0]  reference_dac_channel_a,
	output reg  [8:0]  reference_dac_channel_b
);

	// pin synchronisers, first stage read only by second
	reg        cs_n_meta_reg;
	reg        cs_n_sync_reg;
	reg        cs_n_prev_reg;
	reg        sclk_meta_reg;
	reg        sclk_sync_reg;
	reg        sclk_prev_reg;
	reg        sdi_meta_reg;
	reg        sdi_sync_reg;

	// frame state
	reg [5:0]  edge_cnt_reg;
	reg [15:0] cmd_reg;
	reg [15:0] sr_a_reg;
	reg [15:0] sr_b_reg;
	reg        sdi_seen_low_reg;
	reg        sdi_seen_high_reg;
	reg        rb_pending_reg;
	reg [3:0]  rb_sel_reg;
	reg        rb_frame_reg;
	reg        standby_reg;
	reg        power_down_reg;

	// next values
	reg [5:0]  edge_cnt_next;
	reg        dout_a_next;
	reg        dout_b_next;

	wire       frame_start;
	wire       frame_end;
	wire       sclk_fall;
	wire       selected;
	wire       single_mode;
	wire [5:0] min_edges;
	wire       frame_valid;
	wire       pd_request;
	wire       pd_release;
	wire [3:0] cmd_op;

	// register word returned by a readback command
	function [15:0] readback_word;
		input [3:0]  sel;
		input [11:0] cfg;
		input [8:0]  dac_a;
		input [8:0]  dac_b;
		begin
			if (sel == `DADC_CMD_RD_CONFIG) begin
				readback_word = {sel, cfg};
			end else if (sel == `DADC_CMD_RD_DAC_A) begin
				readback_word = {sel, dac_a, 3'h0};
			end else if (sel == `DADC_CMD_RD_DAC_B) begin
				readback_word = {sel, dac_b, 3'h0};
			end else begin
				readback_word = 16'h0000;
			end
		end
	endfunction

	// two flops on every pin before any logic looks at it
	always @(posedge mclk) begin
		if (rst) begin
			cs_n_meta_reg <= 1'b1;
			cs_n_sync_reg <= 1'b1;
			cs_n_prev_reg <= 1'b1;
			sclk_meta_reg <= 1'b0;
			sclk_sync_reg <= 1'b0;
			sclk_prev_reg <= 1'b0;
			sdi_meta_reg  <= 1'b0;
			sdi_sync_reg  <= 1'b0;
		end else begin
			cs_n_meta_reg <= cs_n;
			cs_n_sync_reg <= cs_n_meta_reg;
			cs_n_prev_reg <= cs_n_sync_reg;
			sclk_meta_reg <= sclk;
			sclk_sync_reg <= sclk_meta_reg;
			sclk_prev_reg <= sclk_sync_reg;
			sdi_meta_reg  <= serial_input;
			sdi_sync_reg  <= sdi_meta_reg;
		end
	end

	// edge detection on the synchronised pins
	assign frame_start = cs_n_prev_reg & ~cs_n_sync_reg;
	assign frame_end   = ~cs_n_prev_reg & cs_n_sync_reg;
	assign selected    = ~cs_n_sync_reg;
	assign sclk_fall   = selected & sclk_prev_reg & ~sclk_sync_reg;

	// readout mode and the edge count that validates a frame
	assign single_mode = ~config_register[`DADC_CFG_MODE_HI] &
	                     config_register[`DADC_CFG_MODE_LO];
	assign min_edges   = single_mode ? `DADC_EDGES_SINGLE :
	                     `DADC_EDGES_DUAL;
	assign frame_valid = (edge_cnt_reg >= min_edges);
	assign cmd_op      = cmd_reg[15:12];

	// power-down requests need 48 edges with a steady serial input
	assign pd_request  = (edge_cnt_reg >= `DADC_EDGES_SINGLE) &
	                     ~sdi_seen_low_reg;
	assign pd_release  = (edge_cnt_reg >= `DADC_EDGES_SINGLE) &
	                     ~sdi_seen_high_reg;

	// saturating falling-edge counter so long frames stay valid
	always @* begin
		edge_cnt_next = edge_cnt_reg;
		if (sclk_fall && edge_cnt_reg != `DADC_EDGE_MAX) begin
			edge_cnt_next = edge_cnt_reg + 6'h01;
		end
	end

	// output bit launched by the current falling edge
	always @* begin
		dout_a_next = 1'b0;
		dout_b_next = 1'b0;
		if (rb_frame_reg) begin
			if (edge_cnt_next >= `DADC_EDGE_RB_FIRST &&
			    edge_cnt_next <= `DADC_EDGE_RB_LAST) begin
				dout_a_next = sr_a_reg[15];
			end
		end else if (single_mode) begin
			if (edge_cnt_next >= `DADC_EDGE_MSB &&
			    edge_cnt_next <= `DADC_EDGE_LAST_SINGLE) begin
				dout_a_next = sr_a_reg[15];
			end
		end else begin
			if (edge_cnt_next >= `DADC_EDGE_MSB &&
			    edge_cnt_next <= `DADC_EDGE_LAST_DUAL) begin
				dout_a_next = sr_a_reg[15];
				dout_b_next = sr_b_reg[15];
			end
		end
	end

	// frame counter, command capture and output shifter
	always @(posedge mclk) begin
		if (rst || cs_n_sync_reg) begin
			edge_cnt_reg <= 6'h00;
		end else begin
			edge_cnt_reg <= edge_cnt_next;
		end
	end

	// shifter loads at frame start; holding the sample keeps aborted bits
	// consistent with it
	always @(posedge mclk) begin
		if (rst) begin
			sr_a_reg          <= 16'h0000;
			sr_b_reg          <= 16'h0000;
			cmd_reg           <= 16'h0000;
			rb_frame_reg      <= 1'b0;
			sdi_seen_low_reg  <= 1'b0;
			sdi_seen_high_reg <= 1'b0;
		end else if (frame_start) begin
			rb_frame_reg      <= rb_pending_reg;
			cmd_reg           <= 16'h0000;
			sdi_seen_low_reg  <= 1'b0;
			sdi_seen_high_reg <= 1'b0;
			if (rb_pending_reg) begin
				sr_a_reg <= readback_word(rb_sel_reg, config_register,
				                          reference_dac_channel_a,
				                          reference_dac_channel_b);
				sr_b_reg <= 16'h0000;
			end else begin
				sr_a_reg <= result_a;
				sr_b_reg <= result_b;
			end
		end else if (sclk_fall) begin
			if (edge_cnt_reg < `DADC_EDGES_CMD) begin
				cmd_reg <= {cmd_reg[14:0], sdi_sync_reg};
			end
			if (edge_cnt_reg < `DADC_EDGES_SINGLE) begin
				if (sdi_sync_reg) begin
					sdi_seen_high_reg <= 1'b1;
				end else begin
					sdi_seen_low_reg <= 1'b1;
				end
			end
			if (rb_frame_reg) begin
				if (edge_cnt_next >= `DADC_EDGE_RB_FIRST &&
				    edge_cnt_next <= `DADC_EDGE_RB_LAST) begin
					sr_a_reg <= {sr_a_reg[14:0], 1'b0};
				end
			end else if (single_mode) begin
				if (edge_cnt_next >= `DADC_EDGE_MSB &&
				    edge_cnt_next <= `DADC_EDGE_LAST_SINGLE) begin
					// channel B follows channel A on one line
					sr_a_reg <= {sr_a_reg[14:0], sr_b_reg[15]};
					sr_b_reg <= {sr_b_reg[14:0], 1'b0};
				end
			end else if (edge_cnt_next >= `DADC_EDGE_MSB &&
			             edge_cnt_next <= `DADC_EDGE_LAST_DUAL) begin
				sr_a_reg <= {sr_a_reg[14:0], 1'b0};
				sr_b_reg <= {sr_b_reg[14:0], 1'b0};
			end
		end
	end

	// registers, readback request and power modes, all updated at frame end
	always @(posedge mclk) begin
		if (rst) begin
			config_register         <= `DADC_CFG_RESET;
			reference_dac_channel_a <= `DADC_DAC_RESET;
			reference_dac_channel_b <= `DADC_DAC_RESET;
			rb_pending_reg          <= 1'b0;
			rb_sel_reg              <= `DADC_CMD_NONE;
			standby_reg             <= 1'b0;
			power_down_reg          <= 1'b0;
		end else if (frame_end) begin
			rb_pending_reg <= 1'b0;
			if (power_down_reg) begin
				// only a steady-low frame wakes it; writes are ignored
				if (pd_release) begin
					power_down_reg <= 1'b0;
				end
			end else if (pd_request) begin
				power_down_reg <= 1'b1;
			end else if (frame_valid) begin
				// first frame after a wake is an ordinary valid write
				case (cmd_op)
				`DADC_CMD_WR_CONFIG: begin
					// exit frame fields take effect with the exit
					config_register <= cmd_reg[11:0];
					standby_reg     <= cmd_reg[`DADC_CFG_STANDBY];
				end
				`DADC_CMD_WR_DAC_A: begin
					reference_dac_channel_a <= cmd_reg[11:3];
				end
				`DADC_CMD_WR_DAC_B: begin
					reference_dac_channel_b <= cmd_reg[11:3];
				end
				`DADC_CMD_RD_CONFIG, `DADC_CMD_RD_DAC_A,
				`DADC_CMD_RD_DAC_B: begin
					rb_pending_reg <= 1'b1;
					rb_sel_reg     <= cmd_op;
				end
				default: begin
					rb_pending_reg <= 1'b0;
				end
				endcase
			end
			// aborted frame falls through with no register change
		end
	end

	// output pins; each comes straight from a flop
	always @(posedge mclk) begin
		if (rst || frame_end || cs_n_sync_reg) begin
			data_out_channel_a    <= 1'b0;
			data_out_channel_a_oe <= 1'b0;
			data_out_channel_b    <= 1'b0;
			data_out_channel_b_oe <= 1'b0;
		end else if (power_down_reg) begin
			data_out_channel_a_oe <= 1'b0;
			data_out_channel_b_oe <= 1'b0;
		end else if (standby_reg) begin
			data_out_channel_a    <= 1'b1;
			data_out_channel_a_oe <= 1'b1;
			data_out_channel_b    <= 1'b1;
			data_out_channel_b_oe <= 1'b1;
		end else if (frame_start) begin
			data_out_channel_a    <= 1'b0;
			data_out_channel_a_oe <= 1'b1;
			data_out_channel_b    <= 1'b0;
			data_out_channel_b_oe <= ~single_mode;
		end else if (sclk_fall) begin
			data_out_channel_a    <= dout_a_next;
			data_out_channel_b    <= dout_b_next & ~single_mode;
			data_out_channel_b_oe <= ~single_mode;
		end
	end

	// conversion start pulse and analog power controls
	always @(posedge mclk) begin
		if (rst) begin
			sample_start       <= 1'b0;
			analog_power_on    <= 1'b1;
			reference_power_on <= 1'b0;
			standby_active     <= 1'b0;
			deep_power_down    <= 1'b0;
		end else begin
			// every frame start outside standby and deep power-down begins a fresh sample, aborted or not
			sample_start       <= frame_start & ~standby_reg &
			                      ~power_down_reg;
			analog_power_on    <= ~standby_reg & ~power_down_reg;
			reference_power_on <= config_register[`DADC_CFG_REF_SEL] &
			                      ~power_down_reg;
			standby_active     <= standby_reg & ~power_down_reg;
			deep_power_down    <= power_down_reg;
		end
	end

endmodule

`default_nettype wire

// ==== verification/dadc_frame_ctrl_chk.sv ====
// concurrent checks on the frame and power control ports
// assumes host pins arrive through two synchroniser flops, outputs one flop later
`timescale 1ns/1ps
`default_nettype none
module dadc_chk (
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// host serial pins and conversion results
	input wire logic        cs_n,
	input wire logic        sclk,
	input wire logic        serial_input,
	input wire logic [15:0] result_a,
	input wire logic [15:0] result_b,
	// data outputs
	input wire logic        data_out_channel_a,
	input wire logic        data_out_channel_a_oe,
	input wire logic        data_out_channel_b,
	input wire logic        data_out_channel_b_oe,
	// power and registers
	input wire logic        sample_start,
	input wire logic        analog_power_on,
	input wire logic        reference_power_on,
	input wire logic        standby_active,
	input wire logic        deep_power_down,
	input wire logic [11:0] config_register,
	input wire logic [8:0]  reference_dac_channel_a,
	input wire logic [8:0]  reference_dac_channel_b
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// six samples cover the synchroniser plus the output flop
	sequence s_desel;
		cs_n[*6];
	endsequence
	sequence s_opened;
		$fell(cs_n) ##1 (!cs_n && !standby_active && !deep_power_down)[*5];
	endsequence
	sequence s_standby_sel;
		(standby_active && !cs_n)[*6];
	endsequence

	a_desel_release: assert property (s_desel |-> !data_out_channel_a_oe && !data_out_channel_b_oe)
		else $error("data output driven while deselected");
	a_open_drive: assert property (s_opened |-> data_out_channel_a_oe)
		else $error("channel A not driven after frame start");
	a_standby_ones: assert property (s_standby_sel |-> data_out_channel_a_oe && data_out_channel_a
		&& data_out_channel_b_oe && data_out_channel_b)
		else $error("standby outputs not all ones");
	a_single_b_off: assert property ((config_register[11:10] == 2'b01) && $stable(config_register)
		&& !standby_active |-> !data_out_channel_b_oe)
		else $error("channel B driven in single-output readout");
	a_pd_release: assert property (deep_power_down && $past(deep_power_down)
		|-> !data_out_channel_a_oe && !data_out_channel_b_oe)
		else $error("output driven in deep power-down");
	a_pd_power_off: assert property (deep_power_down && $past(deep_power_down)
		|-> !analog_power_on && !reference_power_on)
		else $error("circuits powered in deep power-down");
	a_start_pulse: assert property (sample_start |-> analog_power_on ##1 !sample_start)
		else $error("sample start not a single powered pulse");
	a_cfg_frame_end: assert property ($changed(config_register) |-> cs_n && $past(cs_n, 2))
		else $error("configuration changed inside a frame");
endmodule
`default_nettype wire

// ==== verification/dadc_host_model.sv ====
// host side of the serial link: chip select, serial clock, serial input
// assumes the converter oversamples these pins with its own faster clock
`timescale 1ns/1ps
`default_nettype none
module dadc_host_model (
	// link pins driven by the host
	output var logic  cs_n,
	output var logic  sclk,
	output var logic  serial_input,
	// converter data outputs
	input wire logic  data_out_channel_a,
	input wire logic  data_out_channel_a_oe,
	input wire logic  data_out_channel_b,
	input wire logic  data_out_channel_b_oe
);
	logic [47:0] cap_a;
	logic [47:0] cap_b;
	logic [47:0] coe_a;
	logic [47:0] coe_b;

	// idle deselected, clock parked high between frames
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		serial_input = 1'b0;
	end

	// one frame of n falls, 80 ns period; bit k is taken just before fall k+1
	task automatic frame(input logic [15:0] w, input int n);
		int k;
		logic fill;
		fill = &w;
		cap_a = '0;
		cap_b = '0;
		coe_a = '0;
		coe_b = '0;
		#3 cs_n = 1'b0;
		#200;
		for (k = 1; k <= n + 1; k++) begin
			if (k > 1) begin
				cap_a[49 - k] = data_out_channel_a & data_out_channel_a_oe;
				cap_b[49 - k] = data_out_channel_b & data_out_channel_b_oe;
				coe_a[49 - k] = data_out_channel_a_oe;
				coe_b[49 - k] = data_out_channel_b_oe;
			end
			if (k <= n) begin
				serial_input = (k <= 16) ? w[16 - k] : fill;
				#40 sclk = 1'b0;
				#40 sclk = 1'b1;
			end
		end
		cs_n = 1'b1;
		// released line flips so a stale level is never mistaken for data
		serial_input = ~serial_input;
		#120;
	endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the frame and power control block
// assumes the host model paces every frame; no design handshake is awaited
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [15:0] ra = 16'hA5C3;
	localparam logic [15:0] rb = 16'h3C96;
	// bit 47 is the level after fall 1; the MSB leaves at fall 16, bit 32
	localparam logic [47:0] da = {15'h0000, ra, 17'h00000};
	localparam logic [47:0] db = {15'h0000, rb, 17'h00000};
	localparam logic [47:0] sa = {15'h0000, ra, rb, 1'b0};
	localparam logic [47:0] on = 48'hFFFF_FFFF_FFFF;
	localparam logic [47:0] rbk = {4'h3, 12'h400, 32'h0000_0000};
	localparam logic [47:0] z = 48'h0;
	typedef struct {logic [15:0] w; int n; logic [11:0] cfg; logic [1:0] pm; logic [1:0] oe;
		logic ign; logic [47:0] ea; logic [47:0] eb;} dadc_row_t;
	logic mclk, rst, cs_n, sclk, serial_input;
	logic [15:0] result_a, result_b;
	logic data_out_channel_a, data_out_channel_a_oe, data_out_channel_b, data_out_channel_b_oe;
	logic sample_start, analog_power_on, reference_power_on, standby_active, deep_power_down;
	logic [11:0] config_register;
	logic [8:0] reference_dac_channel_a, reference_dac_channel_b;
	int err_total = 0;
	int n_checks = 0;
	dadc_row_t rows [17];
	dadc_row_t r;
	logic [47:0] m;

	dadc_frame_ctrl dut_u (.*);
	dadc_host_model host_u (.*);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic conclude;
		if (err_total == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// reset then compare the idle state of the ports
	task automatic reset_check;
		@(negedge mclk) rst = 1'b1;
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		repeat (3) @(negedge mclk);
		chk("cfg_rst", z, {36'h0, config_register});
		chk("pwr_rst", 48'h4, {44'h0, reference_power_on, analog_power_on, standby_active,
			deep_power_down});
		chk("oe_rst", z, {46'h0, data_out_channel_a_oe, data_out_channel_b_oe});
	endtask

	initial begin
		#200_000;
		err_total++;
		conclude();
	end

	initial begin
		rst = 1'b1;
		result_a = ra;
		result_b = rb;
		rows = '{
			'{16'h0000, 32, 12'h000, 2'b00, 2'b11, 1'b0, da, db},
			'{16'h8400, 32, 12'h400, 2'b00, 2'b11, 1'b0, da, db},
			'{16'h0000, 48, 12'h400, 2'b00, 2'b10, 1'b0, sa, z},
			'{16'h9AB8, 48, 12'h400, 2'b00, 2'b10, 1'b0, sa, z},
			'{16'hA128, 48, 12'h400, 2'b00, 2'b10, 1'b0, sa, z},
			'{16'h8000, 40, 12'h400, 2'b00, 2'b10, 1'b0, sa, z},
			'{16'h3000, 48, 12'h400, 2'b00, 2'b10, 1'b0, sa, z},
			'{16'h0000, 48, 12'h400, 2'b00, 2'b10, 1'b0, rbk, z},
			'{16'h8060, 48, 12'h060, 2'b10, 2'b10, 1'b0, sa, z},
			'{16'h0000, 48, 12'h060, 2'b10, 2'b11, 1'b0, on, on},
			'{16'h8440, 48, 12'h440, 2'b00, 2'b11, 1'b0, on, on},
			'{16'h0000, 48, 12'h440, 2'b00, 2'b10, 1'b0, sa, z},
			'{16'hFFFF, 48, 12'h440, 2'b01, 2'b10, 1'b0, sa, z},
			'{16'hFFFF, 48, 12'h440, 2'b01, 2'b00, 1'b0, z, z},
			'{16'h0000, 48, 12'h440, 2'b00, 2'b00, 1'b0, z, z},
			'{16'h8000, 48, 12'h000, 2'b00, 2'b10, 1'b1, sa, z},
			'{16'h0000, 32, 12'h000, 2'b00, 2'b11, 1'b0, da, db}};
		reset_check();
		// every row: one frame, then registers, power levels and captured streams
		foreach (rows[i]) begin
			r = rows[i];
			host_u.frame(r.w, r.n);
			m = on << (48 - r.n);
			@(negedge mclk);
			chk("cfg", {36'h0, r.cfg}, {36'h0, config_register});
			chk("pwr", {44'h0, r.cfg[6] & ~r.pm[0], ~|r.pm, r.pm}, {44'h0, reference_power_on,
				analog_power_on, standby_active, deep_power_down});
			chk("oe_a", m & {48{r.oe[1]}}, m & host_u.coe_a);
			chk("oe_b", m & {48{r.oe[0]}}, m & host_u.coe_b);
			if (!r.ign) begin
				chk("data_a", m & r.ea, m & host_u.cap_a);
				chk("data_b", m & r.eb, m & host_u.cap_b);
			end
		end
		// dac codes must survive standby and deep power-down
		chk("dac_a", {39'h0, 9'h157}, {39'h0, reference_dac_channel_a});
		chk("dac_b", {39'h0, 9'h025}, {39'h0, reference_dac_channel_b});
		reset_check();
		conclude();
	end
endmodule

bind dadc_frame_ctrl dadc_chk chk_u (.*);
`default_nettype wire
